// ### src/ufc_params.svh
// Constants for the unknown-packet forwarding control registers.
// Assumes inclusion by bare name from design files on the sys_clk domain.
//
// Overview of operation
// - Drive code decodes to 4/8/10/14 mA
// - Reset loads drive code 8 mA; strap loads drive bits after release
// - Strap low 10 mA, high 8 mA
// - Unknown multicast forward enable, bit five
// - Unknown multicast port map, bit0 port1
// - Unknown VID forward enable, bit five
// - Unknown VID port map, zero drops
// - Self-address filter enable, bit six
// - Self filter at egress versus MAC
// - Unknown IP multicast forward enable
// - Unknown IP multicast port map, bits 4:0
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH

`define UFC_ADDR_MCAST_DRV 8'h84
`define UFC_ADDR_VLAN_FWD 8'h85
`define UFC_ADDR_SELF_IPMC 8'h86

`define UFC_DRV_MSB 7
`define UFC_DRV_LSB 6
`define UFC_EN_BIT 5
`define UFC_SELF_BIT 6
`define UFC_MAP_MSB 4
`define UFC_MAP_LSB 0

`define UFC_DRV_RST 2'h1
`define UFC_MAP_RST 5'h00
`define UFC_EN_RST 1'h0
`define UFC_RSVD2_VAL 2'h0
`define UFC_RSVD1_VAL 1'h0
`define UFC_UNMAPPED_VAL 8'h00

`define UFC_DRV_4MA 2'h0
`define UFC_DRV_8MA 2'h1
`define UFC_DRV_10MA 2'h2
`define UFC_DRV_14MA 2'h3
`define UFC_MA_4 4'h4
`define UFC_MA_8 4'h8
`define UFC_MA_10 4'hA
`define UFC_MA_14 4'hE

`define UFC_SYNC_RST 2'h3

`endif

// ### src/ufc_pkg.sv
// Types shared by the unknown-packet forwarding control block.
// Assumes a single sys_clk domain.
package ufc_pkg;

    typedef logic [4:0] ufc_map_t;

    typedef struct packed {
        logic [1:0] drv;
        logic mc_en;
        ufc_map_t mc_map;
        logic vid_en;
        ufc_map_t vid_map;
        logic self_en;
        logic ip_en;
        ufc_map_t ip_map;
        logic strap_done;
        logic [7:0] rdata;
        logic [3:0] drv_ma;
        ufc_map_t mc_fwd;
        ufc_map_t vid_fwd;
        ufc_map_t ip_fwd;
        logic self_out;
        logic egress_drop;
    } ufc_state_t;

    typedef struct packed {
        logic [1:0] sync;
        logic [1:0] valid;
    } ufc_strap_state_t;

endpackage : ufc_pkg

// ### src/ufc_strap_sync.sv
// Strap pin synchroniser with a valid flag once the sample has settled.
// Assumes the strap pin is static around reset release; clock enable gates all state.
`timescale 1ns/1ps
`include "ufc_params.svh"

module ufc_strap_sync (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic drive_strength_strap_pin,
    output logic strap_level,
    output logic strap_valid
);
    import ufc_pkg::*;

    ufc_strap_state_t st_r;
    ufc_strap_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (ce) begin
            st_nxt.sync = {st_r.sync[0], drive_strength_strap_pin};
            // Second stage only valid after a full pass through both flops
            st_nxt.valid = {st_r.valid[0], 1'b1};
        end
    end

    // Reset to the pulled-up level; no port value enters at reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{sync: `UFC_SYNC_RST, valid: 2'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign strap_level = st_r.sync[1];
    assign strap_valid = st_r.valid[1];

endmodule : ufc_strap_sync

// ### src/ufc_fwd_gate.sv
// Combinational decode of drive code and gating of forward port maps.
// Assumes the caller registers every output.
`timescale 1ns/1ps
`include "ufc_params.svh"

module ufc_fwd_gate (
    input wire logic [1:0] drv,
    input wire logic mc_en,
    input wire ufc_pkg::ufc_map_t mc_map,
    input wire logic vid_en,
    input wire ufc_pkg::ufc_map_t vid_map,
    input wire logic ip_en,
    input wire ufc_pkg::ufc_map_t ip_map,
    output logic [3:0] drv_ma,
    output ufc_pkg::ufc_map_t mc_fwd,
    output ufc_pkg::ufc_map_t vid_fwd,
    output ufc_pkg::ufc_map_t ip_fwd
);
    import ufc_pkg::*;

    always_comb begin
        case (drv)
            `UFC_DRV_4MA: drv_ma = `UFC_MA_4;
            `UFC_DRV_8MA: drv_ma = `UFC_MA_8;
            `UFC_DRV_10MA: drv_ma = `UFC_MA_10;
            default: drv_ma = `UFC_MA_14;
        endcase
    end

    // Bit i steers port i+1; a cleared enable leaves the map inert
    genvar i;
    generate
        for (i = 0; i <= `UFC_MAP_MSB; i = i + 1) begin : g_port
            assign mc_fwd[i] = mc_en & mc_map[i];
            assign vid_fwd[i] = vid_en & vid_map[i];
            assign ip_fwd[i] = ip_en & ip_map[i];
        end
    endgenerate

endmodule : ufc_fwd_gate

// ### src/ufc_top.sv
// Global control registers for unknown-packet forwarding, self-address
// filtering and output drive strength.
// Assumes the register access engine and egress path share sys_clk.
`timescale 1ns/1ps
`include "ufc_params.svh"

module ufc_top (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic drive_strength_strap_pin,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [1:0] drive_strength_sel,
    output logic [3:0] drive_strength_ma,
    output ufc_pkg::ufc_map_t unknown_mcast_fwd_map,
    output ufc_pkg::ufc_map_t unknown_vid_fwd_map,
    output ufc_pkg::ufc_map_t unknown_ipmc_fwd_map,
    output logic unknown_mcast_fwd_en,
    output logic unknown_vid_fwd_en,
    output logic unknown_ipmc_fwd_en,
    output logic self_filter_en,
    input wire logic egress_da_valid,
    input wire logic [47:0] egress_da,
    input wire logic [47:0] self_mac,
    output logic egress_self_drop
);
    import ufc_pkg::*;

    ufc_state_t st_r;
    ufc_state_t st_nxt;

    logic strap_level;
    logic strap_valid;
    logic [3:0] drv_ma_c;
    ufc_map_t mc_fwd_c;
    ufc_map_t vid_fwd_c;
    ufc_map_t ip_fwd_c;

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture and decode helpers

    ufc_strap_sync u_strap (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .drive_strength_strap_pin(drive_strength_strap_pin),
        .strap_level(strap_level),
        .strap_valid(strap_valid)
    );

    ufc_fwd_gate u_gate (
        .drv(st_r.drv),
        .mc_en(st_r.mc_en),
        .mc_map(st_r.mc_map),
        .vid_en(st_r.vid_en),
        .vid_map(st_r.vid_map),
        .ip_en(st_r.ip_en),
        .ip_map(st_r.ip_map),
        .drv_ma(drv_ma_c),
        .mc_fwd(mc_fwd_c),
        .vid_fwd(vid_fwd_c),
        .ip_fwd(ip_fwd_c)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_nxt = st_r;
        if (ce) begin
            // Strap is taken once after release; software may override later
            if (!st_r.strap_done && strap_valid) begin
                st_nxt.drv = {~strap_level, strap_level};
                st_nxt.strap_done = 1'b1;
            end

            if (reg_wr) begin
                if (reg_addr == `UFC_ADDR_MCAST_DRV) begin
                    st_nxt.drv = reg_wdata[`UFC_DRV_MSB:`UFC_DRV_LSB];
                    st_nxt.mc_en = reg_wdata[`UFC_EN_BIT];
                    st_nxt.mc_map = reg_wdata[`UFC_MAP_MSB:`UFC_MAP_LSB];
                    // Write before strap sample must not be undone by it
                    st_nxt.strap_done = 1'b1;
                end else if (reg_addr == `UFC_ADDR_VLAN_FWD) begin
                    st_nxt.vid_en = reg_wdata[`UFC_EN_BIT];
                    st_nxt.vid_map = reg_wdata[`UFC_MAP_MSB:`UFC_MAP_LSB];
                end else if (reg_addr == `UFC_ADDR_SELF_IPMC) begin
                    st_nxt.self_en = reg_wdata[`UFC_SELF_BIT];
                    st_nxt.ip_en = reg_wdata[`UFC_EN_BIT];
                    st_nxt.ip_map = reg_wdata[`UFC_MAP_MSB:`UFC_MAP_LSB];
                end
            end

            if (reg_rd) begin
                if (reg_addr == `UFC_ADDR_MCAST_DRV) begin
                    st_nxt.rdata = {st_r.drv, st_r.mc_en, st_r.mc_map};
                end else if (reg_addr == `UFC_ADDR_VLAN_FWD) begin
                    st_nxt.rdata = {`UFC_RSVD2_VAL, st_r.vid_en, st_r.vid_map};
                end else if (reg_addr == `UFC_ADDR_SELF_IPMC) begin
                    st_nxt.rdata = {`UFC_RSVD1_VAL, st_r.self_en, st_r.ip_en,
                                    st_r.ip_map};
                end else begin
                    st_nxt.rdata = `UFC_UNMAPPED_VAL;
                end
            end

            st_nxt.drv_ma = drv_ma_c;
            st_nxt.mc_fwd = mc_fwd_c;
            st_nxt.vid_fwd = vid_fwd_c;
            st_nxt.ip_fwd = ip_fwd_c;
            st_nxt.self_out = st_r.self_en;
            // Egress-side compare; one-cycle drop pulse per frame whose DA matches self_mac while self_en
            st_nxt.egress_drop = egress_da_valid && st_r.self_en
                                 && (egress_da == self_mac);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '{
                drv: `UFC_DRV_RST,
                mc_en: `UFC_EN_RST,
                mc_map: `UFC_MAP_RST,
                vid_en: `UFC_EN_RST,
                vid_map: `UFC_MAP_RST,
                self_en: `UFC_EN_RST,
                ip_en: `UFC_EN_RST,
                ip_map: `UFC_MAP_RST,
                strap_done: 1'b0,
                rdata: `UFC_UNMAPPED_VAL,
                drv_ma: `UFC_MA_8,
                mc_fwd: `UFC_MAP_RST,
                vid_fwd: `UFC_MAP_RST,
                ip_fwd: `UFC_MAP_RST,
                self_out: 1'b0,
                egress_drop: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops

    assign reg_rdata = st_r.rdata;
    assign drive_strength_sel = st_r.drv;
    assign drive_strength_ma = st_r.drv_ma;
    assign unknown_mcast_fwd_map = st_r.mc_fwd;
    assign unknown_vid_fwd_map = st_r.vid_fwd;
    assign unknown_ipmc_fwd_map = st_r.ip_fwd;
    assign unknown_mcast_fwd_en = st_r.mc_en;
    assign unknown_vid_fwd_en = st_r.vid_en;
    assign unknown_ipmc_fwd_en = st_r.ip_en;
    assign self_filter_en = st_r.self_out;
    assign egress_self_drop = st_r.egress_drop;

endmodule : ufc_top

// ### dv/ufc_top_asserts.sv
// Checker for the ufc_top register port, gated VID map and egress self filter.
// Assumes a bind onto ufc_top, single sys_clk domain.
`timescale 1ns/1ps
module ufc_chk (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] drive_strength_sel,
    input wire logic [3:0] drive_strength_ma,
    input wire ufc_pkg::ufc_map_t unknown_vid_fwd_map,
    input wire logic unknown_mcast_fwd_en,
    input wire logic unknown_vid_fwd_en,
    input wire logic self_filter_en,
    input wire logic egress_da_valid,
    input wire logic [47:0] egress_da,
    input wire logic [47:0] self_mac,
    input wire logic egress_self_drop
);
    import ufc_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    function automatic logic [3:0] ma_of(input logic [1:0] s);
        return (s == 2'h0) ? 4'h4 : (s == 2'h1) ? 4'h8 : (s == 2'h2) ? 4'hA : 4'hE;
    endfunction : ma_of
    a_drv_decode: assert property (drive_strength_ma == ma_of($past(drive_strength_sel)))
        else $error("drive mA decode wrong");
    a_drv_write: assert property (ce && reg_wr && reg_addr == 8'h84 |=>
        drive_strength_sel == $past(reg_wdata[7:6])) else $error("drive code not written");
    a_mc_en_write: assert property (ce && reg_wr && reg_addr == 8'h84 |=>
        unknown_mcast_fwd_en == $past(reg_wdata[5])) else $error("mcast enable not written");
    a_vid_en_write: assert property (ce && reg_wr && reg_addr == 8'h85 |=>
        unknown_vid_fwd_en == $past(reg_wdata[5])) else $error("vid enable not written");
    a_vid_map_gate: assert property (ce && reg_wr && reg_addr == 8'h85 ##1 ce |=>
        unknown_vid_fwd_map == ($past(reg_wdata[4:0], 2) & {5{$past(reg_wdata[5], 2)}}))
        else $error("vid forward map wrong");
    a_rd_unmapped: assert property (ce && reg_rd &&
        !(reg_addr inside {8'h84, 8'h85, 8'h86}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rd_reserved: assert property (ce && reg_rd && reg_addr == 8'h85 |=>
        reg_rdata[7:6] == 2'h0) else $error("reserved bits not zero");
    a_self_drop: assert property (ce && egress_da_valid && egress_da == self_mac
        ##1 self_filter_en |-> egress_self_drop) else $error("self frame not dropped");
    a_drop_cause: assert property (egress_self_drop |-> $past(egress_da_valid) &&
        $past(egress_da == self_mac)) else $error("drop without match");
endmodule : ufc_chk
bind ufc_top ufc_chk u_chk (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .drive_strength_sel(drive_strength_sel), .drive_strength_ma(drive_strength_ma),
    .unknown_vid_fwd_map(unknown_vid_fwd_map), .unknown_mcast_fwd_en(unknown_mcast_fwd_en),
    .unknown_vid_fwd_en(unknown_vid_fwd_en), .self_filter_en(self_filter_en),
    .egress_da_valid(egress_da_valid), .egress_da(egress_da), .self_mac(self_mac),
    .egress_self_drop(egress_self_drop));

// ### dv/tb.sv
// Self-checking bench for ufc_top registers and egress self filter.
// Assumes one 50 MHz clock; inputs change by NBA at rising edges.
`timescale 1ns/1ps
module tb;
    import ufc_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic strap = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic da_vld = 1'b0;
    logic [47:0] da = 48'h0;
    logic [47:0] mac = 48'h0A1B2C3D4E5F;
    logic [7:0] rdata;
    logic [1:0] sel;
    logic [3:0] ma;
    ufc_map_t mc_map, vid_map, ip_map;
    logic mc_en, vid_en, ip_en, self_en, drop;
    logic [7:0] ma_tab [4] = '{8'h04, 8'h08, 8'h0A, 8'h0E};
    int fails = 0;
    int total_checks = 0;
    always #10 sys_clk = ~sys_clk;
    ufc_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .drive_strength_strap_pin(strap),
        .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
        .drive_strength_sel(sel), .drive_strength_ma(ma), .unknown_mcast_fwd_map(mc_map),
        .unknown_vid_fwd_map(vid_map), .unknown_ipmc_fwd_map(ip_map),
        .unknown_mcast_fwd_en(mc_en), .unknown_vid_fwd_en(vid_en),
        .unknown_ipmc_fwd_en(ip_en), .self_filter_en(self_en), .egress_da_valid(da_vld),
        .egress_da(da), .self_mac(mac), .egress_self_drop(drop));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s exp %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic do_reset(input logic s);
        @(posedge sys_clk);
        rstn <= 1'b0;
        strap <= s;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
    endtask : do_reset
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("reg_rdata", rdata, exp);
    endtask : rd_reg
    // Drop pulse lasts one cycle, so look right after the taking edge
    task automatic egress(input logic [47:0] d, input logic [7:0] exp);
        @(posedge sys_clk);
        da <= d;
        da_vld <= 1'b1;
        @(posedge sys_clk);
        da_vld <= 1'b0;
        #1;
        chk("egress_self_drop", {7'h00, drop}, exp);
    endtask : egress
    ////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b1);
        chk("drive_strength_sel", {6'h00, sel}, 8'h01);
        rd_reg(8'h84, 8'h40);
        do_reset(1'b0);
        chk("drive_strength_ma", {4'h0, ma}, 8'h0A);
        rd_reg(8'h84, 8'h80);
        rd_reg(8'h85, 8'h00);
        rd_reg(8'h86, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'h84, {i[1:0], 6'h00});
            chk("drive_strength_ma", {4'h0, ma}, ma_tab[i]);
        end
        wr_reg(8'h84, 8'h23);
        chk("unknown_mcast_fwd_map", {3'h0, mc_map}, 8'h03);
        chk("unknown_mcast_fwd_en", {7'h00, mc_en}, 8'h01);
        wr_reg(8'h85, 8'hFF);
        rd_reg(8'h85, 8'h3F);
        chk("unknown_vid_fwd_map", {3'h0, vid_map}, 8'h1F);
        chk("unknown_vid_fwd_en", {7'h00, vid_en}, 8'h01);
        wr_reg(8'h86, 8'hFF);
        rd_reg(8'h86, 8'h7F);
        chk("unknown_ipmc_fwd_map", {3'h0, ip_map}, 8'h1F);
        chk("unknown_ipmc_fwd_en", {7'h00, ip_en}, 8'h01);
        chk("self_filter_en", {7'h00, self_en}, 8'h01);
        egress(mac, 8'h01);
        egress(mac ^ 48'h1, 8'h00);
        wr_reg(8'h85, 8'h15);
        chk("unknown_vid_fwd_map", {3'h0, vid_map}, 8'h00);
        wr_reg(8'h86, 8'h00);
        chk("self_filter_en", {7'h00, self_en}, 8'h00);
        chk("unknown_ipmc_fwd_en", {7'h00, ip_en}, 8'h00);
        egress(mac, 8'h00);
        wr_reg(8'h87, 8'hFF);
        rd_reg(8'h87, 8'h00);
        wrap_up();
    end
    // Whole sequence needs well under 400 cycles
    initial begin
        #100000;
        fails++;
        wrap_up();
    end
endmodule : tb
